/* File: fault_log_pkg.sv */
// Constants, register map and field layout of the fault-log and
// protected-memory register bank.
// Assumes a 32-bit APB master and one clock domain.
// Behaviour
// - Without advanced logging support the pointer register reads zero, ignores writes
// - Pointer bits 63:12 hold the 4KB aligned log region base
// - Base bits at and above host address width are not stored
// - New pointer values are adopted only on the set-log-pointer command
// - Implemented base and size fields read back the last written value
// - Size field bits 11:9 give region size two to X times 4KB
// - Without low or high region support the enable register is read-only
// - Enable register switches on the protected low and high regions
// - Enable bit 31: zero disables, one enables blocking of the regions
// - Status reports enabled only after in-flight translated DMA drains
package fault_log_pkg;
	localparam logic [11:0] ADDR_PTR_LO  = 12'h058;
	localparam logic [11:0] ADDR_PTR_HI  = 12'h05c;
	localparam logic [11:0] ADDR_PMEN    = 12'h064;
	localparam logic [11:0] ADDR_LOGCMD  = 12'h068;
	localparam int          LOG_BASE_LSB = 12;
	localparam int          SIZE_LSB     = 9;
	localparam int          SIZE_MSB     = 11;
	localparam int          HAW_DEF      = 48;
	localparam int          PROT_ON_BIT  = 31;
	localparam int          PROT_STS_BIT = 0;
	localparam int          CMD_SET_BIT  = 0;
	localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
	localparam logic [63:0] PTR_RESET    = 64'h0;
endpackage

/* File: drain_wait.sv */
// Status follower that waits for in-flight translated DMA to drain.
// Assumes inflight_cnt comes from logic on the same clock.
`timescale 1ns/10ps
module drain_wait
	import fault_log_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       prot_on,
	input  wire logic [7:0] inflight_cnt,
	output logic            prot_status
);
	logic sts_r;
	logic sts_nxt;

	always_comb begin
		sts_nxt = sts_r;
		if (!prot_on) begin
			sts_nxt = 1'b0;
		end else if (inflight_cnt == 8'h00) begin
			sts_nxt = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sts_r <= 1'b0;
		end else begin
			sts_r <= sts_nxt;
		end
	end

	assign prot_status = sts_r;

	status_drain_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(sts_r) |-> $past(inflight_cnt) == 8'h00 && $past(prot_on))
		else $error("status rose while DMA in flight");
endmodule

/* File: fault_log_regs.sv */
// APB register bank for the fault-log pointer and protected-memory enable.
// Assumes a 32-bit APB master; zero wait states; capability inputs static.
`timescale 1ns/10ps
module fault_log_regs
	import fault_log_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        adv_logging_supported,
	input  wire logic        low_region_supported,
	input  wire logic        high_region_supported,
	input  wire logic [7:0]  inflight_cnt,
	output logic [63:0]      active_log_ptr,
	output logic             region_protect_on,
	output logic             region_protect_status
);
	////////////////////////////////////////////////////////////////////
	logic [63:0] ptr_r;
	logic [63:0] ptr_nxt;
	logic [63:0] act_r;
	logic [63:0] act_nxt;
	logic        on_r;
	logic        on_nxt;
	logic [31:0] rd_r;
	logic [31:0] rd_nxt;
	logic        err_r;
	logic        err_nxt;
	logic        wr;
	logic        rd;
	logic        hit;
	logic        pm_ok;
	logic [63:0] ptr_mask;
	logic [31:0] wmask;

	assign wr    = psel && penable && pwrite;
	assign rd    = psel && !penable && !pwrite;
	assign pm_ok = low_region_supported || high_region_supported;
	assign hit   = (paddr == ADDR_PTR_LO) || (paddr == ADDR_PTR_HI) ||
		(paddr == ADDR_PMEN) || (paddr == ADDR_LOGCMD);

	always_comb begin
		ptr_mask = '0;
		ptr_mask[HAW_DEF-1:LOG_BASE_LSB] = '1;
		ptr_mask[SIZE_MSB:SIZE_LSB] = '1;
	end

	always_comb begin
		wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	end

	////////////////////////////////////////////////////////////////////
	always_comb begin
		ptr_nxt = ptr_r;
		act_nxt = act_r;
		on_nxt  = on_r;
		if (wr && adv_logging_supported) begin
			if (paddr == ADDR_PTR_LO) begin
				ptr_nxt[31:0] = ((pwdata & wmask) | (ptr_r[31:0] & ~wmask)) &
					ptr_mask[31:0];
			end
			if (paddr == ADDR_PTR_HI) begin
				ptr_nxt[63:32] = ((pwdata & wmask) | (ptr_r[63:32] & ~wmask)) &
					ptr_mask[63:32];
			end
			if (paddr == ADDR_LOGCMD && pstrb[0] && pwdata[CMD_SET_BIT]) begin
				act_nxt = ptr_r;
			end
		end
		if (wr && pm_ok && paddr == ADDR_PMEN && pstrb[3]) begin
			on_nxt = pwdata[PROT_ON_BIT];
		end
	end

	always_comb begin
		rd_nxt  = rd_r;
		err_nxt = err_r;
		if (rd) begin
			err_nxt = !hit;
			rd_nxt  = ZERO_WORD;
			if (adv_logging_supported && paddr == ADDR_PTR_LO) begin
				rd_nxt = ptr_r[31:0];
			end
			if (adv_logging_supported && paddr == ADDR_PTR_HI) begin
				rd_nxt = ptr_r[63:32];
			end
			if (paddr == ADDR_PMEN) begin
				rd_nxt[PROT_ON_BIT]  = on_r;
				rd_nxt[PROT_STS_BIT] = region_protect_status;
			end
		end else if (psel && !penable) begin
			err_nxt = !hit;
			rd_nxt  = ZERO_WORD;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_r <= PTR_RESET;
			act_r <= PTR_RESET;
			on_r  <= 1'b0;
			rd_r  <= ZERO_WORD;
			err_r <= 1'b0;
		end else begin
			ptr_r <= ptr_nxt;
			act_r <= act_nxt;
			on_r  <= on_nxt;
			rd_r  <= rd_nxt;
			err_r <= err_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Status lags enable so blocking is never reported early
	drain_wait u_drain (
		.pclk         (pclk),
		.presetn      (presetn),
		.prot_on      (on_r),
		.inflight_cnt (inflight_cnt),
		.prot_status  (region_protect_status)
	);

	assign prdata            = rd_r;
	assign pready            = 1'b1;
	assign pslverr           = psel && penable && err_r;
	assign active_log_ptr    = act_r;
	assign region_protect_on = on_r;

	////////////////////////////////////////////////////////////////////
	no_log_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!adv_logging_supported |=> $stable(ptr_r))
		else $error("pointer changed without logging support");
	low_bits_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		ptr_r[SIZE_LSB-1:0] == '0)
		else $error("reserved pointer bits set");
	high_bits_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		ptr_r[63:HAW_DEF] == '0)
		else $error("unimplemented base bits set");
	adopt_cmd_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!(wr && paddr == ADDR_LOGCMD) |=> $stable(act_r))
		else $error("active pointer moved without command");
	pm_ro_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!pm_ok |=> $stable(on_r))
		else $error("enable written without region support");
	enable_wr_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && pm_ok && paddr == ADDR_PMEN && pstrb[3]
		|=> on_r == $past(pwdata[PROT_ON_BIT]))
		else $error("enable bit not taken");
	off_status_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!on_r |=> !region_protect_status)
		else $error("status high while disabled");
	size_rb_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && adv_logging_supported && paddr == ADDR_PTR_LO && pstrb[1]
		|=> ptr_r[SIZE_MSB:SIZE_LSB] == $past(pwdata[SIZE_MSB:SIZE_LSB]))
		else $error("size field not stored");

	////////////////////////////////////////////////////////////////////
	// Steps of a transfer, named once so the properties read as a walk
	sequence lo_read_s;
		rd && adv_logging_supported && paddr == ADDR_PTR_LO;
	endsequence

	sequence hi_read_s;
		rd && adv_logging_supported && paddr == ADDR_PTR_HI;
	endsequence

	sequence blank_read_s;
		rd && !adv_logging_supported &&
			(paddr == ADDR_PTR_LO || paddr == ADDR_PTR_HI);
	endsequence

	sequence set_cmd_s;
		wr && adv_logging_supported && paddr == ADDR_LOGCMD &&
			pstrb[0] && pwdata[CMD_SET_BIT];
	endsequence

	sequence pm_read_s;
		rd && paddr == ADDR_PMEN;
	endsequence

	// Enabled with nothing left in flight: the drain is complete
	sequence drained_s;
		on_r && inflight_cnt == 8'h00;
	endsequence

	// Enabled but translated DMA still outstanding
	sequence draining_s;
		on_r && inflight_cnt != 8'h00 && !region_protect_status;
	endsequence

	////////////////////////////////////////////////////////////////////
	lo_readback_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		lo_read_s |=> rd_r == $past(ptr_r[31:0]))
		else $error("low pointer word not read back");
	hi_readback_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		hi_read_s |=> rd_r == $past(ptr_r[63:32]))
		else $error("high pointer word not read back");
	rsvd_read_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		lo_read_s |=> rd_r[SIZE_LSB-1:0] == '0)
		else $error("reserved pointer bits read nonzero");
	blank_read_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		blank_read_s |=> rd_r == ZERO_WORD)
		else $error("pointer readable without logging support");
	cmd_copy_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		set_cmd_s |=> act_r == $past(ptr_r))
		else $error("command did not adopt the pointer");
	pm_read_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		pm_read_s |=> rd_r[PROT_ON_BIT] == $past(on_r))
		else $error("enable bit not read back");
	drain_hold_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		draining_s |=> !region_protect_status)
		else $error("status reported before drain");
	drain_done_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		drained_s |=> region_protect_status)
		else $error("status missing after drain");
	status_on_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		region_protect_status |-> $past(on_r))
		else $error("status without enable");
endmodule

/* File: test_fault_log_and_protected_mem_regs.sv */
// Testbench for the fault-log and protected-memory register bank.
// Assumes zero-wait APB answers and static capability inputs per reset.
`timescale 1ns/10ps
module test_fault_log_and_protected_mem_regs
	import fault_log_pkg::*;
;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0]  pstrb = 4'hf;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        adv = 1;
	logic        lo = 1;
	logic        hi = 1;
	logic [7:0]  inflight = '0;
	logic [63:0] active_log_ptr;
	logic        prot_on;
	logic        prot_sts;
	logic [31:0] rd;
	logic        er;
	int          err_total = 0;
	int          cmp_count = 0;

	always #2 pclk = ~pclk;

	fault_log_regs u_fault_log_regs (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .adv_logging_supported(adv),
		.low_region_supported(lo), .high_region_supported(hi),
		.inflight_cnt(inflight), .active_log_ptr(active_log_ptr),
		.region_protect_on(prot_on), .region_protect_status(prot_sts));

	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t saw %h want %h", $time, seen, exp);
		end
	endtask

	// Samples at the completing edge, before that edge's updates land
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic do_reset(input logic a, input logic l, input logic h);
		@(posedge pclk);
		presetn <= 1'b0;
		adv <= a;
		lo <= l;
		hi <= h;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_pointer();
		apb(1, 12'h058, 32'hffff_ffff);
		apb(1, 12'h05c, 32'hffff_ffff);
		apb(0, 12'h058, 32'h0);
		check(rd, 32'hffff_fe00);
		apb(0, 12'h05c, 32'h0);
		check(rd, 32'h0000_ffff);
		check(active_log_ptr, 64'h0);
		apb(1, 12'h068, 32'h1);
		@(negedge pclk);
		check(active_log_ptr, 64'h0000_ffff_ffff_fe00);
		apb(1, 12'h058, 32'h0012_3a00);
		apb(0, 12'h058, 32'h0);
		check(rd, 32'h0012_3a00);
		check(rd[11:9], 3'h5);
		check(rd[31:12], 20'h00123);
		$display("pointer test done");
	endtask

	// Status must wait for the in-flight count to reach zero
	task automatic t_enable();
		inflight <= 8'h03;
		apb(1, 12'h064, 32'h8000_0000);
		repeat (3) @(negedge pclk);
		check(prot_on, 1'b1);
		check(prot_sts, 1'b0);
		@(posedge pclk);
		inflight <= 8'h00;
		repeat (3) @(negedge pclk);
		check(prot_sts, 1'b1);
		apb(0, 12'h064, 32'h0);
		check(rd, 32'h8000_0001);
		apb(1, 12'h064, 32'h0);
		@(negedge pclk);
		check(prot_on, 1'b0);
		apb(1, 12'h100, 32'h1);
		check(er, 1'b1);
		apb(0, 12'h058, 32'h0);
		check(er, 1'b0);
		$display("enable test done");
	endtask

	task automatic t_nocap();
		do_reset(0, 0, 0);
		apb(1, 12'h058, 32'hffff_f200);
		apb(0, 12'h058, 32'h0);
		check(rd, 32'h0);
		apb(1, 12'h068, 32'h1);
		@(negedge pclk);
		check(active_log_ptr, 64'h0);
		apb(1, 12'h064, 32'h8000_0000);
		@(negedge pclk);
		check(prot_on, 1'b0);
		$display("no capability test done");
	endtask

	initial begin
		do_reset(1, 1, 1);
		t_pointer();
		t_enable();
		t_nocap();
		print_verdict();
	end

	initial begin
		#20000;
		err_total++;
		print_verdict();
	end
endmodule
